/* rtl/ptm_pkg.sv */
// Purpose: Shared constants and types for the periodic timer block
// Assumes: 8-bit register port, 10-bit counter
// Notes:   Register indexes are byte addresses on the plain register port
package ptm_pkg;

  localparam int CNT_W  = 10;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;

  // Register indexes
  localparam logic [ADDR_W-1:0] REG_CTRL0   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CTRL1   = 4'h1;
  localparam logic [ADDR_W-1:0] REG_CNT_LO  = 4'h2;
  localparam logic [ADDR_W-1:0] REG_CNT_HI  = 4'h3;
  localparam logic [ADDR_W-1:0] REG_CMPA_LO = 4'h4;
  localparam logic [ADDR_W-1:0] REG_CMPA_HI = 4'h5;
  localparam logic [ADDR_W-1:0] REG_PER_LO  = 4'h6;
  localparam logic [ADDR_W-1:0] REG_PER_HI  = 4'h7;
  localparam logic [ADDR_W-1:0] REG_FLAGS   = 4'h8;
  localparam logic [ADDR_W-1:0] REG_INTEN   = 4'h9;

  // Field positions
  localparam int RUN_BIT = 3;
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int FUNC_HI = 5;
  localparam int FUNC_LO = 4;
  localparam int OC_BIT  = 3;
  localparam int POL_BIT = 2;
  localparam int CAPTS   = 1;
  localparam int CCLR    = 0;
  localparam int FLAG_A  = 0;
  localparam int FLAG_P  = 1;
  localparam int HI_W    = CNT_W - DATA_W;

  // Reset and special values
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 10'h000;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 10'h001;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0]        PAIR_ZERO = 2'h0;

  typedef enum logic [1:0] {
    PTM_MODE_CMP = 2'h0,
    PTM_MODE_CAP = 2'h1,
    PTM_MODE_PWM = 2'h2,
    PTM_MODE_TMR = 2'h3
  } ptm_mode_type;

  // Pin-function codes, meaning depends on mode
  localparam logic [1:0] CMP_NOCHG  = 2'h0;
  localparam logic [1:0] CMP_LOW    = 2'h1;
  localparam logic [1:0] CMP_HIGH   = 2'h2;
  localparam logic [1:0] CMP_TOGGLE = 2'h3;
  localparam logic [1:0] PWM_INACT  = 2'h0;
  localparam logic [1:0] PWM_ACT    = 2'h1;
  localparam logic [1:0] PWM_WAVE   = 2'h2;
  localparam logic [1:0] PWM_SINGLE = 2'h3;
  localparam logic [1:0] CAP_RISE   = 2'h0;
  localparam logic [1:0] CAP_FALL   = 2'h1;
  localparam logic [1:0] CAP_BOTH   = 2'h2;
  localparam logic [1:0] CAP_OFF    = 2'h3;

endpackage

/* rtl/ptm_edge.sv */
// Purpose: Rising and falling edge detect on synchronous pin inputs
// Assumes: Inputs already synchronous to clk
// Notes:   One-cycle pulses, in the same cycle as the level change
`timescale 1ns/100ps
module ptm_edge #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Levels in, edges out
  input  wire logic [W-1:0] sig,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] prev;
  } ptm_edge_type;

  ptm_edge_type s_r;
  ptm_edge_type s_nxt;

  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.prev = sig;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  for (genvar i = 0; i < W; i++)
  begin : g_bit
    assign rise[i] = sig[i] & ~s_r.prev[i];
    assign fall[i] = ~sig[i] & s_r.prev[i];
  end

endmodule // ptm_edge

/* rtl/ptm_clkdiv.sv */
// Purpose: Timer clock enable from the system clock
// Assumes: DIV of 1 gives a tick every cycle
// Notes:   Free running, so the timer clock phase is not tied to run
`timescale 1ns/100ps
module ptm_clkdiv #(
  parameter int DIV = 1
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Enable pulse
  output logic      tick
);

  localparam int            CW   = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  localparam logic [CW-1:0] STEP = CW'(1);

  typedef struct packed {
    logic [CW-1:0] cnt;
  } ptm_div_type;

  ptm_div_type s_r;
  ptm_div_type s_nxt;

  assign tick = (s_r.cnt == LAST);

  always_comb
  begin
    s_nxt     = s_r;
    s_nxt.cnt = tick ? '0 : s_r.cnt + STEP;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

endmodule // ptm_clkdiv

/* rtl/ptm_top.sv */
// Purpose: 10-bit periodic timer with compare, PWM, single pulse and capture
// Assumes: Pins synchronous to MCLK; timer clock is an enable from a divider
// Notes:   Compare and period registers take effect at once, no buffering
`timescale 1ns/100ps

// Notes on behaviour
// [RULE1] Mode 00 is compare output; counter cleared by overflow, A or P match.
// [RULE2] Clear-select low clears on P match, or overflow if period zero; both flags.
// [RULE3] Clear-select high clears on A match; only the A flag is ever raised.
// [RULE4] Compare A of zero runs to 3FF and overflows without an A flag.
// [RULE5] Software keeps compare A nonzero in compare output mode.
// [RULE6] Compare mode pin changes only on A match: low, high, toggle or nothing.
// [RULE7] Compare mode pin takes the initial level on a run rise.
// [RULE8] Mode 11 counts and flags like compare mode but leaves the pin unused.
// [RULE9] PWM period is period value counts, zero meaning 1024; A sets duty.
// [RULE10] Duty at or above period gives a fully active output.
// [RULE11] PWM raises A flag on A match and P flag on P match.
// [RULE12] PWM level polarity from initial level bit, function bits, invert bit.
// [RULE13] PWM counting keeps running while function bits force a fixed level.
// [RULE14] Single pulse is mode 10 with function 11; run rise starts the pulse.
// [RULE15] External clock pin edge sets the run bit in single pulse mode.
// [RULE16] A match clears run, ends the pulse, flags; software clear ends it too.
// [RULE17] Single pulse counter returns to zero only on run rise; no period use.
// [RULE18] Capture mode 01; source pin selectable; rising, falling or both edges.
// [RULE19] Capture copies counter into compare A and flags; counter keeps running.
// [RULE20] Capture mode P match clears the counter and flags; zero gives full range.
// [RULE21] Capture function 11 disables capture while the counter runs on.
// [RULE22] Counter latched within 1.5 timer clocks; A flag follows latching.
// [RULE23] Run rise zeroes the counter; run fall stops it holding its value.
// [RULE24] Flags stay set until cleared and request an interrupt when enabled.
module ptm_top #(
  parameter int PRESCALE = 1
) (
  // Clock and reset
  input  wire logic                         MCLK,
  input  wire logic                         SYS_RST,
  // Register port
  input  wire logic [ptm_pkg::ADDR_W-1:0]   REG_ADDR,
  input  wire logic [ptm_pkg::DATA_W-1:0]   REG_WDATA,
  input  wire logic                         REG_WR,
  input  wire logic                         REG_RD,
  output logic      [ptm_pkg::DATA_W-1:0]   REG_RDATA,
  // Pins
  input  wire logic                         CAPTURE_INPUT_PIN,
  input  wire logic                         EXT_CLOCK_PIN,
  output logic                              TIMER_OUTPUT_PIN_O,
  output logic                              TIMER_OUTPUT_PIN_OE,
  // Status
  output logic                              MATCH_A_FLAG,
  output logic                              MATCH_P_FLAG,
  output logic                              INT_REQ
);

  import ptm_pkg::*;

  typedef struct packed {
    logic              run;
    logic [DATA_W-1:0] ctrl1;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  cmpa;
    logic [CNT_W-1:0]  per;
    logic              flag_a;
    logic              flag_p;
    logic [1:0]        inten;
    logic              out;
    logic              cap_pend;
    logic              pin;
    logic              pin_oe;
    logic              irq;
    logic [DATA_W-1:0] rdata;
  } ptm_state_type;

  ptm_state_type    s_r;
  ptm_state_type    s_nxt;
  ptm_mode_type     mode;
  ptm_mode_type     nmode;
  logic [1:0]       func;
  logic [1:0]       nfunc;
  logic             tick;
  logic [1:0]       pin_rise;
  logic [1:0]       pin_fall;
  logic             src_rise;
  logic             src_fall;
  logic [CNT_W-1:0] cnt_inc;
  logic             cmp_like;
  logic             sp_mode;
  logic             a_hit;
  logic             p_hit;
  logic             cap_evt;
  logic             ext_trig;
  logic             a_set;
  logic             p_set;
  logic             pwm_on;
  logic             lvl;

  ptm_clkdiv #(
    .DIV  (PRESCALE)
  ) u_div (
    .clk  (MCLK),
    .rst  (SYS_RST),
    .tick (tick)
  );

  // Index 1 is the external clock pin, index 0 the capture pin
  ptm_edge #(
    .W    (2)
  ) u_edge (
    .clk  (MCLK),
    .rst  (SYS_RST),
    .sig  ({EXT_CLOCK_PIN, CAPTURE_INPUT_PIN}),
    .rise (pin_rise),
    .fall (pin_fall)
  );

  assign mode     = ptm_mode_type'(s_r.ctrl1[MODE_HI:MODE_LO]);
  assign func     = s_r.ctrl1[FUNC_HI:FUNC_LO];
  assign cnt_inc  = s_r.cnt + CNT_ONE;
  assign cmp_like = (mode == PTM_MODE_CMP) || (mode == PTM_MODE_TMR); // see [RULE8]
  assign sp_mode  = (mode == PTM_MODE_PWM) && (func == PWM_SINGLE); // see [RULE14]

  // Matches look at the next count, so a period of zero wraps at 3FF
  assign a_hit = s_r.run && tick && (s_r.cmpa != CNT_ZERO) && (cnt_inc == s_r.cmpa); // see [RULE4]
  assign p_hit = s_r.run && tick && (cnt_inc == s_r.per); // see [RULE9] see [RULE20]

  assign src_rise = s_r.ctrl1[CAPTS] ? pin_rise[1] : pin_rise[0]; // see [RULE18]
  assign src_fall = s_r.ctrl1[CAPTS] ? pin_fall[1] : pin_fall[0];

  // Capture is taken on the system clock, well inside the timer clock bound
  always_comb
  begin
    cap_evt = 1'b0;
    if (s_r.run && (mode == PTM_MODE_CAP))
    begin
      unique case (func)
        CAP_RISE: cap_evt = src_rise;
        CAP_FALL: cap_evt = src_fall;
        CAP_BOTH: cap_evt = src_rise | src_fall;
        CAP_OFF:  cap_evt = 1'b0; // see [RULE21]
      endcase
    end
  end

  assign ext_trig = sp_mode && pin_rise[1]; // see [RULE15]

  always_comb
  begin
    a_set = 1'b0;
    p_set = 1'b0;
    unique case (mode)
      PTM_MODE_CMP, PTM_MODE_TMR:
      begin
        a_set = a_hit; // see [RULE2]
        p_set = p_hit && !s_r.ctrl1[CCLR]; // see [RULE3]
      end
      PTM_MODE_PWM:
      begin
        a_set = a_hit; // see [RULE11] see [RULE16]
        p_set = p_hit && !sp_mode; // see [RULE17]
      end
      PTM_MODE_CAP:
      begin
        a_set = s_r.cap_pend; // see [RULE22]
        p_set = p_hit; // see [RULE20]
      end
    endcase
  end

  always_comb
  begin
    s_nxt = s_r;
    pwm_on = 1'b0;
    lvl = 1'b0;

    // Register writes
    if (REG_WR)
    begin
      unique case (REG_ADDR)
        REG_CTRL0:   s_nxt.run = REG_WDATA[RUN_BIT];
        REG_CTRL1:   s_nxt.ctrl1 = REG_WDATA;
        REG_CMPA_LO: s_nxt.cmpa[DATA_W-1:0] = REG_WDATA;
        REG_CMPA_HI: s_nxt.cmpa[CNT_W-1:DATA_W] = REG_WDATA[HI_W-1:0];
        REG_PER_LO:  s_nxt.per[DATA_W-1:0] = REG_WDATA;
        REG_PER_HI:  s_nxt.per[CNT_W-1:DATA_W] = REG_WDATA[HI_W-1:0];
        REG_FLAGS:
        begin
          if (REG_WDATA[FLAG_A])
            s_nxt.flag_a = 1'b0;
          if (REG_WDATA[FLAG_P])
            s_nxt.flag_p = 1'b0;
        end
        REG_INTEN:   s_nxt.inten = REG_WDATA[1:0];
        default:     s_nxt.inten = s_r.inten;
      endcase
    end

    // Counting on the timer clock; stopped counter keeps its value
    if (s_r.run && tick) // see [RULE23] see [RULE13]
    begin
      s_nxt.cnt = cnt_inc;
      unique case (mode)
        PTM_MODE_CMP, PTM_MODE_TMR:
        begin
          if (s_r.ctrl1[CCLR] ? a_hit : p_hit) // see [RULE1] see [RULE2] see [RULE3]
            s_nxt.cnt = CNT_ZERO;
        end
        PTM_MODE_PWM:
        begin
          if (!sp_mode && p_hit) // see [RULE9] see [RULE17]
            s_nxt.cnt = CNT_ZERO;
        end
        PTM_MODE_CAP:
        begin
          if (p_hit) // see [RULE20]
            s_nxt.cnt = CNT_ZERO;
        end
      endcase
    end

    // Capture wins over a same-cycle software write to compare A
    s_nxt.cap_pend = cap_evt;
    if (cap_evt)
      s_nxt.cmpa = s_r.cnt; // see [RULE19] see [RULE22]

    // Compare output pin state, P matches have no say
    if ((mode == PTM_MODE_CMP) && a_hit) // see [RULE6]
    begin
      unique case (func)
        CMP_NOCHG:  s_nxt.out = s_r.out;
        CMP_LOW:    s_nxt.out = 1'b0;
        CMP_HIGH:   s_nxt.out = 1'b1;
        CMP_TOGGLE: s_nxt.out = ~s_r.out;
      endcase
    end

    // Pulse end by A match, then pin trigger, which wins
    if (sp_mode && a_hit)
      s_nxt.run = 1'b0; // see [RULE16]
    if (ext_trig)
      s_nxt.run = 1'b1; // see [RULE15]

    // Run rise restarts count and reloads the initial pin level
    if (s_nxt.run && !s_r.run)
    begin
      s_nxt.cnt = CNT_ZERO; // see [RULE23] see [RULE17]
      s_nxt.out = s_nxt.ctrl1[OC_BIT]; // see [RULE7]
    end

    // Hardware set wins over software clear
    if (a_set)
      s_nxt.flag_a = 1'b1; // see [RULE24]
    if (p_set)
      s_nxt.flag_p = 1'b1; // see [RULE24]
    s_nxt.irq = |({s_nxt.flag_p, s_nxt.flag_a} & s_nxt.inten); // see [RULE24]

    // Pin from the next state so it lines up with counter and flags
    nmode = ptm_mode_type'(s_nxt.ctrl1[MODE_HI:MODE_LO]);
    nfunc = s_nxt.ctrl1[FUNC_HI:FUNC_LO];
    pwm_on = (s_nxt.cnt < s_nxt.cmpa) ||
             ((s_nxt.per != CNT_ZERO) && (s_nxt.cmpa >= s_nxt.per)); // see [RULE10]
    unique case (nmode)
      PTM_MODE_CMP:
      begin
        s_nxt.pin    = s_nxt.out ^ s_nxt.ctrl1[POL_BIT];
        s_nxt.pin_oe = 1'b1;
      end
      PTM_MODE_PWM:
      begin
        unique case (nfunc)
          PWM_INACT:  lvl = 1'b0; // see [RULE13]
          PWM_ACT:    lvl = 1'b1;
          PWM_WAVE:   lvl = pwm_on;
          PWM_SINGLE: lvl = s_nxt.run; // see [RULE14] see [RULE16]
        endcase
        s_nxt.pin    = (lvl ? s_nxt.ctrl1[OC_BIT] : ~s_nxt.ctrl1[OC_BIT]) ^
                       s_nxt.ctrl1[POL_BIT]; // see [RULE12]
        s_nxt.pin_oe = 1'b1;
      end
      PTM_MODE_CAP, PTM_MODE_TMR:
      begin
        s_nxt.pin    = 1'b0; // see [RULE8]
        s_nxt.pin_oe = 1'b0;
      end
    endcase

    // Read data for the cycle after the strobe only
    s_nxt.rdata = BYTE_ZERO;
    if (REG_RD)
    begin
      unique case (REG_ADDR)
        REG_CTRL0:   s_nxt.rdata = BYTE_ZERO | (DATA_W'(s_r.run) << RUN_BIT);
        REG_CTRL1:   s_nxt.rdata = s_r.ctrl1;
        REG_CNT_LO:  s_nxt.rdata = s_r.cnt[DATA_W-1:0];
        REG_CNT_HI:  s_nxt.rdata = DATA_W'(s_r.cnt[CNT_W-1:DATA_W]);
        REG_CMPA_LO: s_nxt.rdata = s_r.cmpa[DATA_W-1:0];
        REG_CMPA_HI: s_nxt.rdata = DATA_W'(s_r.cmpa[CNT_W-1:DATA_W]);
        REG_PER_LO:  s_nxt.rdata = s_r.per[DATA_W-1:0];
        REG_PER_HI:  s_nxt.rdata = DATA_W'(s_r.per[CNT_W-1:DATA_W]);
        REG_FLAGS:   s_nxt.rdata = DATA_W'({s_r.flag_p, s_r.flag_a});
        REG_INTEN:   s_nxt.rdata = DATA_W'(s_r.inten);
        default:     s_nxt.rdata = BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign REG_RDATA           = s_r.rdata;
  assign TIMER_OUTPUT_PIN_O  = s_r.pin;
  assign TIMER_OUTPUT_PIN_OE = s_r.pin_oe;
  assign MATCH_A_FLAG        = s_r.flag_a;
  assign MATCH_P_FLAG        = s_r.flag_p;
  assign INT_REQ             = s_r.irq;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);

  sequence s_capture;
    cap_evt;
  endsequence

  sequence s_latched_then_flag(logic [CNT_W-1:0] v);
    (s_r.cmpa == v) ##1 s_r.flag_a;
  endsequence

  property p_capture_latch; // see [RULE19]
    logic [CNT_W-1:0] v;
    (s_capture, v = s_r.cnt) |=> s_latched_then_flag(v);
  endproperty
  a_capture_latch: assert property (p_capture_latch)
    else $error("capture did not latch counter then set A flag");

  property p_run_rise_zero; // see [RULE23]
    $rose(s_r.run) |-> (s_r.cnt == CNT_ZERO);
  endproperty
  a_run_rise_zero: assert property (p_run_rise_zero)
    else $error("counter not zero after run rise");

  property p_stopped_holds; // see [RULE23]
    (!s_r.run && $past(!s_r.run)) |-> $stable(s_r.cnt);
  endproperty
  a_stopped_holds: assert property (p_stopped_holds)
    else $error("counter moved while stopped");

  property p_p_clear; // see [RULE2]
    (cmp_like && !s_r.ctrl1[CCLR] && p_hit) |=> (s_r.cnt == CNT_ZERO) && s_r.flag_p;
  endproperty
  a_p_clear: assert property (p_p_clear)
    else $error("P match did not clear counter and flag");

  property p_no_p_flag; // see [RULE3]
    (cmp_like && s_r.ctrl1[CCLR] && !s_r.flag_p) |=> !s_r.flag_p;
  endproperty
  a_no_p_flag: assert property (p_no_p_flag)
    else $error("P flag raised with A-match clear");

  property p_zero_a_no_flag; // see [RULE4]
    (s_r.cmpa == CNT_ZERO && mode != PTM_MODE_CAP && !s_r.cap_pend && !s_r.flag_a)
      |=> !s_r.flag_a;
  endproperty
  a_zero_a_no_flag: assert property (p_zero_a_no_flag)
    else $error("A flag raised with compare A zero");

  property p_full_duty; // see [RULE10]
    (mode == PTM_MODE_PWM && func == PWM_WAVE && s_r.per != CNT_ZERO &&
     s_r.cmpa >= s_r.per) |-> (s_r.pin == (s_r.ctrl1[OC_BIT] ^ s_r.ctrl1[POL_BIT]));
  endproperty
  a_full_duty: assert property (p_full_duty)
    else $error("PWM not fully active with duty above period");

  property p_pulse_end; // see [RULE16]
    (sp_mode && a_hit && !ext_trig) |=> !s_r.run ##1 $stable(s_r.cnt);
  endproperty
  a_pulse_end: assert property (p_pulse_end)
    else $error("single pulse did not stop on A match");

  property p_set_wins; // see [RULE24]
    (REG_WR && REG_ADDR == REG_FLAGS && REG_WDATA[FLAG_A] && a_set) |=> s_r.flag_a;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("A flag lost to a same-cycle clear");

endmodule // ptm_top

/* dv/ptm_pin_model.sv */
// Purpose: Pin-side partner: capture and trigger sources, output load
// Assumes: Source levels change by NBA just after a rising MCLK edge
// Notes:   Output line is pulled up whenever the timer releases it
`timescale 1ns/100ps
module ptm_pin_model (
  // Clock
  input  wire logic MCLK,
  // Timer output pin
  input  wire logic PIN_O,
  input  wire logic PIN_OE,
  // Sources and resolved line
  output logic      CAP_PIN,
  output logic      EXT_PIN,
  output wire logic PIN_LEVEL
);
  initial
  begin
    CAP_PIN = 1'h0;
    EXT_PIN = 1'h0;
  end
  // Released line reads the pull-up, never the last driven value
  assign PIN_LEVEL = PIN_OE ? PIN_O : 1'h1;
  task automatic drive(input int sel, input logic v);
    @(posedge MCLK);
    if (sel == 1) EXT_PIN <= v;
    else CAP_PIN <= v;
  endtask
  // Never shorter than two ticks, so no pulse may be dropped
  task automatic pulse(input int sel, input int w);
    drive(sel, 1'h1);
    repeat ((w < 2) ? 2 : w) @(posedge MCLK);
    drive(sel, 1'h0);
  endtask
endmodule // ptm_pin_model

/* dv/periodic_timer_modes_tb.sv */
// Purpose: Self-checking bench for the periodic timer
// Assumes: PRESCALE 1, so the counter steps every MCLK cycle
// Notes:   Expected figures are derived from mode rules and task timing
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((e) !== (g)) begin bad_count++; \
  $display("FAIL %s exp %0h got %0h", n, e, g); end end
module periodic_timer_modes_tb;
  import ptm_pkg::*;
  logic              mclk = 1'h0;
  logic              sys_rst = 1'h1;
  logic              reg_wr = 1'h0;
  logic              reg_rd = 1'h0;
  logic [ADDR_W-1:0] reg_addr = 4'h0;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic [DATA_W-1:0] reg_rdata;
  logic              pin_o, pin_oe, pin, cap, ext, fa, fp, irq;
  int                bad_count = 0;
  int                checked = 0;
  always #20 mclk = ~mclk;
  ptm_top #(.PRESCALE(1)) u_dut (
    .MCLK(mclk), .SYS_RST(sys_rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .CAPTURE_INPUT_PIN(cap), .EXT_CLOCK_PIN(ext), .TIMER_OUTPUT_PIN_O(pin_o),
    .TIMER_OUTPUT_PIN_OE(pin_oe), .MATCH_A_FLAG(fa), .MATCH_P_FLAG(fp), .INT_REQ(irq));
  ptm_pin_model u_pins (.MCLK(mclk), .PIN_O(pin_o), .PIN_OE(pin_oe), .CAP_PIN(cap),
    .EXT_PIN(ext), .PIN_LEVEL(pin));
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  // Two reads, four edges; not atomic on a running counter
  task automatic rd10(input logic [ADDR_W-1:0] a, output logic [CNT_W-1:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(a, lo);
    rd(a + 4'h1, hi);
    v = {hi[1:0], lo};
  endtask
  task automatic run(input logic on);
    wr(REG_CTRL0, {4'h0, on, 3'h0});
  endtask
  task automatic cfg(input logic [7:0] c, input logic [9:0] a, input logic [9:0] p);
    run(1'h0);
    wr(REG_CTRL1, c);
    wr(REG_CMPA_LO, a[7:0]);
    wr(REG_CMPA_HI, {6'h00, a[9:8]});
    wr(REG_PER_LO, p[7:0]);
    wr(REG_PER_HI, {6'h00, p[9:8]});
    wr(REG_FLAGS, 8'h03);
  endtask
  task automatic gap(output int n);
    logic p0;
    p0 = pin;
    n = 0;
    do begin @(posedge mclk); #1 n++; end while (pin === p0 && n < 2100);
  endtask
  task automatic pw(output int n);
    n = 0;
    #1;
    repeat (50) if (pin !== 1'h1) begin @(posedge mclk); #1; end
    while (pin === 1'h1 && n < 2000) begin @(posedge mclk); #1 n++; end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #(40 * 40000);
    bad_count++;
    tally_and_finish();
  end
  initial
  begin
    logic [7:0] d, d2;
    logic [9:0] v0, v1, v2;
    logic [1:0] f;
    int         n, h, per, act, cs, dr;
    int         pp[7] = '{8, 8, 8, 8, 8, 8, 0};
    int         aa[7] = '{3, 3, 3, 9, 3, 3, 3};
    logic [1:0] ff[7] = '{PWM_WAVE, PWM_WAVE, PWM_WAVE, PWM_WAVE, PWM_INACT, PWM_ACT, PWM_WAVE};
    logic       oo[7] = '{1, 0, 1, 1, 1, 1, 1};
    logic       ll[7] = '{0, 0, 1, 0, 0, 0, 0};
    void'($urandom(8));
    cyc(4);
    sys_rst <= 1'h0;
    for (int a = 0; a < 16; a++) begin rd(a[3:0], d); `CHK("reset", 8'h00, d) end
    d = $urandom;
    wr(REG_PER_HI, d);
    rd(REG_PER_HI, d2);
    `CHK("per hi", {6'h00, d[1:0]}, d2)
    wr(4'hF, d);
    wr(REG_CNT_LO, d);
    rd(4'hF, d2);
    `CHK("unmapped", 8'h00, d2)
    rd(REG_CNT_LO, d2);
    `CHK("cnt ro", 8'h00, d2)
    cfg({PTM_MODE_CMP, CMP_TOGGLE, 4'h9}, 10'd5, 10'd2);
    run(1'h1);
    `CHK("init hi", 1'h1, pin)
    gap(n);
    gap(n);
    `CHK("a clear", 5, n)
    cyc(20);
    `CHK("a only", 2'h1, {fp, fa})
    // Clears two cycles apart hit every phase of a five-count match
    repeat (5) wr(REG_FLAGS, 8'h01);
    cfg({PTM_MODE_CMP, CMP_HIGH, 4'h0}, 10'd3, 10'd7);
    run(1'h1);
    `CHK("init lo", 1'h0, pin)
    gap(n);
    `CHK("a match", 3, n)
    cyc(20);
    `CHK("p ignored", 1'h1, pin)
    `CHK("both", 2'h3, {fp, fa})
    wr(REG_INTEN, 8'h01);
    cyc(1);
    `CHK("irq a", 1'h1, irq)
    run(1'h0);
    wr(REG_INTEN, 8'h02);
    wr(REG_FLAGS, 8'h01);
    cyc(1);
    `CHK("clear a", 2'h2, {fp, fa})
    `CHK("irq p", 1'h1, irq)
    wr(REG_FLAGS, 8'h02);
    cyc(1);
    `CHK("irq off", 1'h0, irq)
    // No change keeps the initial high, output low drops it on A match
    for (int k = 0; k < 2; k++) begin
      cfg({PTM_MODE_CMP, 2'(k), 4'h8}, 10'd3, 10'd7);
      run(1'h1);
      cyc(5);
      `CHK("low or none", k == 0, pin)
    end
    // Zero compare A only in timer mode
    cfg({PTM_MODE_TMR, CMP_TOGGLE, 4'h8}, 10'd0, 10'd0);
    run(1'h1);
    `CHK("tmr oe", 1'h0, pin_oe)
    cyc(1100);
    `CHK("ovf", 2'h2, {fp, fa})
    run(1'h0);
    rd10(REG_CNT_LO, v0);
    cyc(5);
    rd10(REG_CNT_LO, v1);
    `CHK("hold", v0, v1)
    run(1'h1);
    rd(REG_CNT_LO, d);
    `CHK("restart", 1'h1, d < 8)
    for (int k = 0; k < 7; k++) begin
      per = (pp[k] == 0) ? 1024 : pp[k];
      act = (ff[k] == PWM_ACT) ? per : (ff[k] == PWM_INACT) ? 0 : (aa[k] >= per) ? per : aa[k];
      cfg({PTM_MODE_PWM, ff[k], oo[k], ll[k], 2'h0}, 10'(aa[k]), 10'(pp[k]));
      run(1'h1);
      cyc(per);
      h = 0;
      repeat (2 * per) begin @(posedge mclk); #1 h += (pin === 1'h1); end
      `CHK("pwm high", 2 * ((oo[k] ^ ll[k]) ? act : per - act), h)
      // A duty past the period is never reached, so no A match
      `CHK("pwm flags", {1'h1, aa[k] < per}, {fp, fa})
    end
    cfg({PTM_MODE_PWM, PWM_SINGLE, 4'h8}, 10'd6, 10'd0);
    run(1'h1);
    pw(n);
    `CHK("pulse", 6, n)
    rd(REG_CTRL0, d);
    `CHK("run off", 8'h00, d)
    rd10(REG_CNT_LO, v0);
    `CHK("no wrap", 10'd6, v0)
    `CHK("sp flag", 1'h1, fa)
    fork
      u_pins.pulse(1, 3);
      pw(n);
    join
    `CHK("ext pulse", 6, n)
    wr(REG_CMPA_LO, 8'h28);
    run(1'h1);
    cyc(10);
    run(1'h0);
    `CHK("sw end", 1'h0, pin)
    rd10(REG_CNT_LO, v0);
    `CHK("kept", 1'h1, v0 >= 10 && v0 < 40)
    for (int k = 0; k < 8; k++) begin
      cs = k % 2;
      f = 2'(k / 2);
      dr = 4 + $urandom % 16;
      cfg({PTM_MODE_CAP, f, 2'h0, cs[0], 1'h0}, 10'd0, 10'd0);
      run(1'h1);
      cyc(8);
      u_pins.drive(1 - cs, 1'h1);
      cyc(4);
      rd10(REG_CMPA_LO, v0);
      `CHK("other pin", 10'd0, v0)
      u_pins.drive(cs, 1'h1);
      cyc(2);
      rd10(REG_CMPA_LO, v1);
      cyc(dr);
      u_pins.drive(cs, 1'h0);
      cyc(4);
      rd10(REG_CMPA_LO, v2);
      `CHK("rise cap", f == CAP_RISE || f == CAP_BOTH, v1 !== v0)
      `CHK("fall cap", f == CAP_FALL || f == CAP_BOTH, v2 !== v1)
      // Fall lands dr plus seven edges after rise
      if (f == CAP_BOTH) `CHK("span", 10'(dr + 7), v2 - v1)
      `CHK("cap flag", f != CAP_OFF, fa)
      u_pins.drive(1 - cs, 1'h0);
    end
    cfg({PTM_MODE_CAP, CAP_OFF, 4'h0}, 10'd0, 10'd20);
    run(1'h1);
    // Each wait passes a full period so the P clear is really exercised
    repeat (5) begin
      cyc(20 + $urandom % 7);
      rd(REG_CNT_LO, d);
      `CHK("cap range", 1'h1, d < 20)
    end
    `CHK("cap p", 1'h1, fp)
    tally_and_finish();
  end
endmodule // periodic_timer_modes_tb
